// >>> logic/adc_cycle_serial_readout.sv
`timescale 1ns/1ps
module adc_cycle_serial_readout import adc_cycle_pkg::*; #(
    parameter int unsigned CONV_TICKS = CONV_OSC_CYCLES,
    parameter int unsigned POR_LEN = POR_CYCLES,
    parameter int unsigned FIFO_DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sck,
    output logic o_sck,
    output logic o_sck_oe,
    output logic o_sck_pullup,
    output logic o_sdo,
    output logic o_sdo_oe,
    input wire logic i_freq_select_pin,
    input wire logic i_supply_low,
    input wire logic i_sample_valid,
    input wire logic [SAMPLE_BITS-1:0] i_sample,
    output logic o_sample_ready,
    output logic o_ext_sysclk,
    output logic o_over_range,
    output logic o_under_range
);
    state_type state;
    state_type next_state;
    logic cs_m, cs_s, cs_d;
    logic sck_m, sck_s, sck_d;
    logic f_m, f_s, f_d;
    logic low_m, low_s;
    logic cs_rise, cs_fall, f_rise;
    logic ext_active;
    logic [31:0] idle_cnt;
    logic [31:0] div_cnt;
    logic osc_tick;
    logic [31:0] conv_cnt;
    logic [31:0] por_cnt;
    logic conv_done;
    logic int_mode;
    logic int_sck;
    logic [31:0] half_cnt;
    logic int_fall;
    logic sck_fall;
    logic [4:0] bit_cnt;
    logic [WORD_BITS-1:0] shift_word;
    logic fifo_rd_valid;
    logic [SAMPLE_BITS-1:0] fifo_rd_data;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_d <= 1'b1;
            sck_m <= 1'b1;
            sck_s <= 1'b1;
            sck_d <= 1'b1;
            f_m <= 1'b0;
            f_s <= 1'b0;
            f_d <= 1'b0;
            low_m <= 1'b0;
            low_s <= 1'b0;
        end else begin
            cs_m <= i_cs_n;
            cs_s <= cs_m;
            cs_d <= cs_s;
            sck_m <= i_sck;
            sck_s <= sck_m;
            sck_d <= sck_s;
            f_m <= i_freq_select_pin;
            f_s <= f_m;
            f_d <= f_s;
            low_m <= i_supply_low;
            low_s <= low_m;
        end
    end

    assign cs_rise = cs_s && !cs_d;
    assign cs_fall = !cs_s && cs_d;
    assign f_rise = f_s && !f_d;

    // ----------------------------------------
    // system clock source
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ext_active <= 1'b0;
            idle_cnt <= '0;
        end else if (f_s != f_d) begin
            ext_active <= 1'b1;
            idle_cnt <= '0;
        end else if (idle_cnt == FREQ_IDLE_CYCLES - 1) begin
            ext_active <= 1'b0;
        end else begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div_cnt <= '0;
            osc_tick <= 1'b0;
        end else if (ext_active) begin
            div_cnt <= '0;
            osc_tick <= f_rise;
        end else if (div_cnt >= (f_s ? OSC_DIV_50 : OSC_DIV_60) - 1) begin
            div_cnt <= '0;
            osc_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            osc_tick <= 1'b0;
        end
    end

    // ----------------------------------------
    // operating cycle
    // ----------------------------------------
    assign conv_done = (state == s_convert) && (conv_cnt >= CONV_TICKS) && fifo_rd_valid;
    assign sck_fall = int_mode ? int_fall : (sck_d && !sck_s);

    always_comb begin
        next_state = state;
        unique case (state)
            s_por: begin
                if (por_cnt == '0) begin
                    next_state = s_convert;
                end
            end
            s_convert: begin
                if (conv_done) begin
                    next_state = s_sleep;
                end
            end
            s_sleep: begin
                if (!cs_s) begin
                    next_state = s_output;
                end
            end
            s_output: begin
                if (cs_rise || (sck_fall && bit_cnt == LAST_FALL)) begin
                    next_state = s_convert;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= s_por;
            por_cnt <= POR_LEN - 1;
        end else if (low_s) begin
            state <= s_por;
            por_cnt <= POR_LEN - 1;
        end else begin
            state <= next_state;
            if (state == s_por && por_cnt != '0) begin
                por_cnt <= por_cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            conv_cnt <= '0;
        end else if (state != s_convert) begin
            conv_cnt <= '0;
        end else if (osc_tick && conv_cnt < CONV_TICKS) begin
            conv_cnt <= conv_cnt + 1'b1;
        end
    end

    // ----------------------------------------
    // clock mode and internal serial clock
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            int_mode <= 1'b1;
        end else if ((state == s_por && por_cnt == '0) || cs_fall) begin
            int_mode <= sck_s;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            int_sck <= 1'b1;
            half_cnt <= '0;
            int_fall <= 1'b0;
        end else if (state != s_output || !int_mode) begin
            int_sck <= 1'b1;
            half_cnt <= '0;
            int_fall <= 1'b0;
        end else if (osc_tick && half_cnt == ISCK_HALF_TICKS - 1) begin
            int_sck <= !int_sck;
            half_cnt <= '0;
            int_fall <= int_sck;
        end else begin
            if (osc_tick) begin
                half_cnt <= half_cnt + 1'b1;
            end
            int_fall <= 1'b0;
        end
    end

    // ----------------------------------------
    // result word and shifting
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_word <= RESET_WORD;
            bit_cnt <= '0;
        end else if (state == s_por) begin
            shift_word <= RESET_WORD;
            bit_cnt <= '0;
        end else if (conv_done) begin
            shift_word <= {1'b0, 1'b0, fifo_rd_data};
            bit_cnt <= '0;
        end else if (state == s_output && sck_fall) begin
            shift_word <= {shift_word[WORD_BITS-2:0], 1'b1};
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_over_range <= 1'b0;
            o_under_range <= 1'b0;
        end else if (state == s_por) begin
            o_over_range <= 1'b0;
            o_under_range <= 1'b0;
        end else if (conv_done) begin
            o_over_range <= fifo_rd_data[SIGN_POS] && fifo_rd_data[MSB_POS];
            o_under_range <= !fifo_rd_data[SIGN_POS] && !fifo_rd_data[MSB_POS];
        end
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sdo <= 1'b1;
            o_sdo_oe <= 1'b0;
        end else begin
            o_sdo_oe <= !cs_s;
            if (state == s_output) begin
                o_sdo <= shift_word[WORD_BITS-1];
            end else begin
                o_sdo <= (state != s_sleep);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sck <= 1'b1;
            o_sck_oe <= 1'b0;
            o_sck_pullup <= 1'b1;
            o_ext_sysclk <= 1'b0;
        end else begin
            o_sck <= int_sck;
            o_sck_oe <= (state == s_output) && int_mode;
            o_sck_pullup <= int_mode;
            o_ext_sysclk <= ext_active;
        end
    end

    sample_fifo #(
        .WIDTH(SAMPLE_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_sample_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr_valid(i_sample_valid),
        .o_wr_ready(o_sample_ready),
        .i_wr_data(i_sample),
        .o_rd_valid(fifo_rd_valid),
        .i_rd_ready(conv_done),
        .o_rd_data(fifo_rd_data)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence last_fall_seq;
        state == s_output && !cs_rise && !low_s && sck_fall && bit_cnt == LAST_FALL;
    endsequence

    sequence restart_seq;
        state == s_convert ##1 o_sdo;
    endsequence

    chk_cycle_order: assert property (
        $changed(state) && state == s_sleep |-> $past(state) == s_convert)
        else $error("sleep entered from wrong state");
    chk_sleep_hold: assert property (
        state == s_sleep && cs_s && !low_s |=> state == s_sleep)
        else $error("left sleep with select high");
    chk_wake_output: assert property (
        state == s_sleep && !cs_s && !low_s |=> state == s_output && o_sdo_oe)
        else $error("select low did not start output");
    chk_abort_restart: assert property (
        state == s_output && cs_rise && !low_s |=> state == s_convert)
        else $error("select rise did not abort");
    chk_sdo_float: assert property (
        cs_s |=> !o_sdo_oe)
        else $error("data out driven while deselected");
    chk_status_flag: assert property (
        state != s_output && state != s_por && !cs_s |=> o_sdo == ($past(state) != s_sleep))
        else $error("status flag wrong");
    chk_sck_drive: assert property (
        o_sck_oe |-> $past(state) == s_output && $past(int_mode))
        else $error("clock driven outside internal output");
    chk_mode_latch: assert property (
        cs_fall |=> int_mode == $past(sck_s) ##1 o_sck_pullup == $past(int_mode))
        else $error("clock mode not latched");
    chk_sleep_stable: assert property (
        state == s_sleep && !low_s |=> $stable(shift_word))
        else $error("result changed in sleep");
    chk_result_load: assert property (
        conv_done && !low_s |=> shift_word == {2'b00, $past(fifo_rd_data)})
        else $error("loaded word not latest result");
    chk_word_end: assert property (
        last_fall_seq |=> restart_seq)
        else $error("32nd edge did not restart conversion");
    chk_range_flags: assert property (
        state == s_sleep |-> o_over_range == (shift_word[SIGN_POS] && shift_word[MSB_POS]))
        else $error("range flag mismatch");
    chk_por_exit: assert property (
        state == s_por && por_cnt == '0 && !low_s |=> state == s_convert && conv_cnt == '0)
        else $error("reset did not start conversion");
endmodule

// >>> include/adc_cycle_pkg.sv
package adc_cycle_pkg;

    // ----------------------------------------
    // clock and oscillator rates
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 200000000;
    localparam int unsigned OSC_HZ_50 = 128000;
    localparam int unsigned OSC_HZ_60 = 153600;
    localparam int unsigned OSC_DIV_50 = CLK_HZ / OSC_HZ_50;
    localparam int unsigned OSC_DIV_60 = CLK_HZ / OSC_HZ_60;
    localparam int unsigned NOTCH_DIVIDE = 2560;
    localparam int unsigned ISCK_DIV = 8;
    localparam int unsigned ISCK_HALF_TICKS = ISCK_DIV / 2;
    localparam int unsigned FREQ_IDLE_CYCLES = 4096;

    // ----------------------------------------
    // conversion and reset timing
    // ----------------------------------------
    localparam int unsigned CONV_OSC_CYCLES = 20510;
    localparam int unsigned POR_TIME_US = 1000;
    localparam int unsigned POR_CYCLES = POR_TIME_US * (CLK_HZ / 1000000);

    // ----------------------------------------
    // output word layout
    // ----------------------------------------
    localparam int unsigned WORD_BITS = 32;
    localparam int unsigned SAMPLE_BITS = 30;
    localparam int unsigned SIGN_POS = 29;
    localparam int unsigned MSB_POS = 28;
    localparam logic [4:0] LAST_FALL = 5'h1f;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        s_por = 2'b00,
        s_convert = 2'b01,
        s_sleep = 2'b10,
        s_output = 2'b11
    } state_type;

endpackage

// >>> logic/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
    parameter int unsigned WIDTH = 30,
    parameter int unsigned DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign push = i_wr_valid && o_wr_ready;
    assign pop = i_rd_ready && o_rd_valid;
    assign o_rd_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // ----------------------------------------
    // storage and pointers
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
        end
    end

    // ----------------------------------------
    // registered flags
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count <= '0;
            o_wr_ready <= 1'b1;
            o_rd_valid <= 1'b0;
        end else begin
            count <= next_count;
            o_wr_ready <= (next_count != FULL_COUNT);
            o_rd_valid <= (next_count != '0);
        end
    end
endmodule

// >>> testbench/host_serial_model.sv
`timescale 1ns/1ps
module host_serial_model (
    input wire logic i_clk,
    input wire logic i_sck_line,
    input wire logic i_sdo_line,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_sck_oe
);
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_sck_oe = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // --------------------------------
    // chip select and waits
    // --------------------------------
    task automatic select(input logic v);
        @(negedge i_clk);
        o_cs_n = v;
    endtask

    task automatic wait_ready(output logic ok);
        ok = 1'b0;
        tick(6);
        for (int i = 0; i < 4000 && !ok; i++) begin
            @(negedge i_clk);
            ok = (i_sdo_line === 1'b0);
        end
    endtask

    // --------------------------------
    // external clock readout, capture on rise
    // --------------------------------
    task automatic read_ext(input int n, output logic [31:0] w);
        w = 32'h0000_0000;
        for (int k = 0; k < n; k++) begin
            o_sck = 1'b1;
            w[31-k] = i_sdo_line;
            tick(8);
            o_sck = 1'b0;
            tick(8);
        end
    endtask

    // --------------------------------
    // internal clock: sck high at select fall, then released
    // --------------------------------
    task automatic int_setup();
        @(negedge i_clk);
        o_sck = 1'b1;
        tick(4);
        o_cs_n = 1'b0;
        tick(12);
        o_sck_oe = 1'b0;
    endtask

    task automatic read_int(output logic [31:0] w, output int falls);
        logic prev_sck;
        logic prev_sdo;
        w = 32'h0000_0000;
        falls = 0;
        prev_sck = 1'b1;
        prev_sdo = 1'b1;
        for (int i = 0; i < 6000 && falls < 32; i++) begin
            @(negedge i_clk);
            if (prev_sck && !i_sck_line) begin
                w[31-falls] = prev_sdo;
                falls++;
            end
            prev_sck = i_sck_line;
            prev_sdo = i_sdo_line;
        end
    endtask
endmodule

// >>> testbench/adc_cycle_serial_readout_tb.sv
`timescale 1ns/1ps
module adc_cycle_serial_readout_tb import adc_cycle_pkg::*; ;
    logic i_clk = 1'b0;
    logic i_rst;
    logic cs_n, h_sck, h_oe, o_sck, o_sck_oe, o_sck_pullup, o_sdo, o_sdo_oe;
    logic freq = 1'b0;
    logic freq_run = 1'b0;
    logic [1:0] freq_div = 2'h0;
    logic supply_low;
    logic s_valid;
    logic [SAMPLE_BITS-1:0] s_data;
    logic s_ready, ext_sysclk, over, under, sck_line, sdo_line;
    logic last_sck = 1'b0;
    logic last_sdo = 1'b0;
    logic ok;
    logic [31:0] w;
    int falls;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [SAMPLE_BITS-1:0] samp [5] = '{30'h3abc_de01, 30'h0123_4567, 30'h2555_5555,
        30'h3aaa_aaaa, 30'h3c3c_3c3c};

    always #2.5 i_clk = ~i_clk;

    // undriven lines show the inverse of their last driven level, except sck, which reads high while o_sck_pullup is set
    assign sck_line = o_sck_oe ? o_sck : (h_oe ? h_sck : (o_sck_pullup ? 1'b1 : ~last_sck));
    assign sdo_line = o_sdo_oe ? o_sdo : ~last_sdo;
    always @(posedge i_clk) begin
        if (o_sck_oe || h_oe || o_sck_pullup) begin
            last_sck <= sck_line;
        end
        if (o_sdo_oe) begin
            last_sdo <= o_sdo;
        end
    end

    always @(negedge i_clk) begin
        if (freq_run) begin
            freq_div <= freq_div + 2'h1;
            if (freq_div == 2'h3) freq <= ~freq;
        end
    end

    adc_cycle_serial_readout #(
        .CONV_TICKS(8),
        .POR_LEN(16),
        .FIFO_DEPTH(4)
    ) u_adc_cycle_serial_readout (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_cs_n(cs_n),
        .i_sck(sck_line),
        .o_sck(o_sck),
        .o_sck_oe(o_sck_oe),
        .o_sck_pullup(o_sck_pullup),
        .o_sdo(o_sdo),
        .o_sdo_oe(o_sdo_oe),
        .i_freq_select_pin(freq),
        .i_supply_low(supply_low),
        .i_sample_valid(s_valid),
        .i_sample(s_data),
        .o_sample_ready(s_ready),
        .o_ext_sysclk(ext_sysclk),
        .o_over_range(over),
        .o_under_range(under)
    );

    host_serial_model u_host_serial_model (
        .i_clk(i_clk),
        .i_sck_line(sck_line),
        .i_sdo_line(sdo_line),
        .o_cs_n(cs_n),
        .o_sck(h_sck),
        .o_sck_oe(h_oe)
    );

    // --------------------------------
    // checking and closing
    // --------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            $display("CHECK FAILED timeout expected %h seen %h", 0, cycles);
            close_out();
        end
    end

    initial begin
        i_rst = 1'b1;
        supply_low = 1'b0;
        s_valid = 1'b0;
        s_data = '0;
        repeat (5) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (40) @(negedge i_clk);
        check("pullup", 0, o_sck_pullup);
        check("sdo_oe", 0, o_sdo_oe);
        check("ranges", 0, {over, under});
        repeat (4200) @(negedge i_clk);
        check("ext_sysclk static", 0, ext_sysclk);
        freq_run = 1'b1;
        repeat (100) @(negedge i_clk);
        check("ext_sysclk", 1, ext_sysclk);
        $display("test mode_pins done");
        // fill the buffer until it refuses
        for (int i = 0; i < 5; i++) begin
            s_data = samp[i];
            s_valid = 1'b1;
            check("sample_ready", 1, s_ready);
            @(negedge i_clk);
        end
        s_valid = 1'b0;
        check("sample_ready full", 0, s_ready);
        $display("test fill done");
        // full external readout
        u_host_serial_model.select(1'b0);
        u_host_serial_model.wait_ready(ok);
        check("conversion done", 1, ok);
        check("over_range", 1, over);
        u_host_serial_model.read_ext(32, w);
        check("word0", {2'b00, samp[0]}, w);
        check("sdo after 32nd", 1, sdo_line);
        u_host_serial_model.select(1'b1);
        $display("test read done");
        // aborted readout then restart
        u_host_serial_model.select(1'b0);
        u_host_serial_model.wait_ready(ok);
        check("under_range", 1, under);
        check("sample_ready drain", 1, s_ready);
        u_host_serial_model.read_ext(8, w);
        check("word1 head", {2'b00, samp[1][29:24]}, w[31:24]);
        u_host_serial_model.select(1'b1);
        repeat (6) @(negedge i_clk);
        check("sdo_oe deselect", 0, o_sdo_oe);
        u_host_serial_model.select(1'b0);
        repeat (5) @(negedge i_clk);
        check("status pending", 2'b11, {o_sdo_oe, sdo_line});
        u_host_serial_model.wait_ready(ok);
        check("status done", 1, ok);
        u_host_serial_model.select(1'b1);
        repeat (500) @(negedge i_clk);
        check("sleep sdo_oe", 0, o_sdo_oe);
        u_host_serial_model.select(1'b0);
        repeat (5) @(negedge i_clk);
        check("sleep status", 0, sdo_line);
        u_host_serial_model.read_ext(32, w);
        check("word3", {2'b00, samp[3]}, w);
        u_host_serial_model.select(1'b1);
        $display("test abort done");
        // internal clock readout
        repeat (20) @(negedge i_clk);
        u_host_serial_model.int_setup();
        check("pullup internal", 1, o_sck_pullup);
        u_host_serial_model.read_int(w, falls);
        check("falls", 32, falls);
        check("word4", {2'b00, samp[4]}, w);
        repeat (8) @(negedge i_clk);
        check("sdo after internal", 1, sdo_line);
        check("sck_oe released", 0, o_sck_oe);
        u_host_serial_model.select(1'b1);
        $display("test internal done");
        // brown-out clears the flags
        check("over before", 1, over);
        supply_low = 1'b1;
        repeat (10) @(negedge i_clk);
        supply_low = 1'b0;
        repeat (40) @(negedge i_clk);
        check("ranges cleared", 0, {over, under});
        $display("test brownout done");
        close_out();
    end
endmodule
